// File: rtl/cpu_ctrl_pkg.sv
/*
  Constants and types shared by the processor control-input logic.
  Assumes a single processor clock and no software-visible registers.
*/
package cpu_ctrl_pkg;

  // Bus cycle states, wait_state included
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_T1,
    BUS_T2,
    BUS_T3,
    BUS_WAIT_STATE,
    BUS_T4
  } bus_st_e;

  // Interrupt sequencer states
  typedef enum logic [1:0] {
    INT_IDLE,
    INT_ACK,
    INT_VEC
  } int_st_e;

  localparam int          SYNC_STAGES       = 2;
  localparam int          CTRL_SYNC_WIDTH   = 4;
  localparam int          RESET_MIN_CYCLES  = 4;
  localparam int          VEC_ADDR_WIDTH    = 20;
  localparam int          VEC_TYPE_WIDTH    = 8;
  localparam logic [7:0]  NMI_TYPE          = 8'h02;
  localparam logic [19:0] VEC_TABLE_BASE    = 20'h00000;
  localparam logic [9:0]  VEC_ADDR_PAD      = 10'h000;
  localparam logic [1:0]  VEC_ENTRY_LSBS    = 2'h0;
  localparam logic [7:0]  TYPE_RESET_VALUE  = 8'h00;

  // Sync vector bit positions
  localparam int          SYNC_BIT_IRQ      = 0;
  localparam int          SYNC_BIT_TEST     = 1;
  localparam int          SYNC_BIT_NMI      = 2;
  localparam int          SYNC_BIT_RESET    = 3;

endpackage : cpu_ctrl_pkg

// File: rtl/sync_2ff.sv
/*
  Two-flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : sync_2ff

// File: rtl/nmi_edge_latch.sv
/*
  Rising-edge detector with a sticky pending flag for the non-maskable input.
  Assumes level_i is already synchronised to clk_i.
*/
`timescale 1ns/1ps
module nmi_edge_latch (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic abort_i,
  input  wire logic level_i,
  input  wire logic clear_i,
  output logic      pending_o
);

  logic prev_q;
  logic pend_q;
  logic pend_d;
  logic rise_w;

  assign rise_w = level_i & ~prev_q;
  // A new edge in the clearing cycle is kept
  assign pend_d = rise_w | (pend_q & ~clear_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (abort_i) begin
      prev_q <= level_i;
      pend_q <= 1'b0;
    end else begin
      prev_q <= level_i;
      pend_q <= pend_d;
    end
  end

  assign pending_o = pend_q;

endmodule : nmi_edge_latch

// File: rtl/cpu_control_inputs.sv
/*
  Control-input logic of the processor: ready/wait states with the read
  strobe, maskable and non-maskable interrupt entry, wait-release test and
  reset. Assumes the core signals instruction boundaries and bus requests,
  and that ready_i arrives already synchronous to clk_i.
*/
`timescale 1ns/1ps
module cpu_control_inputs
  import cpu_ctrl_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      reset_i,
  input  wire logic                      ready_i,
  input  wire logic                      maskable_irq_in_i,
  input  wire logic                      test_i,
  input  wire logic                      nmi_i,
  input  wire logic                      instr_last_i,
  input  wire logic                      int_enable_i,
  input  wire logic                      wait_instr_i,
  input  wire logic                      bus_start_i,
  input  wire logic                      bus_read_i,
  input  wire logic                      bus_released_i,
  input  wire logic                      ack_type_valid_i,
  input  wire logic [VEC_TYPE_WIDTH-1:0] ack_type_i,
  output logic                           rd_strobe_n_o,
  output bus_st_e                        bus_state_o,
  output logic                           irq_ack_o,
  output logic                           vector_fetch_o,
  output logic [VEC_ADDR_WIDTH-1:0]      vector_addr_o,
  output logic [VEC_TYPE_WIDTH-1:0]      vector_type_o,
  output logic                           wait_idle_o,
  output logic                           core_reset_o,
  output logic                           restart_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [CTRL_SYNC_WIDTH-1:0] sync_w;
  logic                       irq_sync_w;
  logic                       test_sync_w;
  logic                       nmi_sync_w;
  logic                       rst_sync_w;

  // ready_i is deliberately left out: it must already be clock-synchronous
  sync_2ff #(
    .WIDTH (CTRL_SYNC_WIDTH)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({reset_i, nmi_i, test_i, maskable_irq_in_i}),
    .q_o     (sync_w)
  );

  assign irq_sync_w  = sync_w[SYNC_BIT_IRQ];
  assign test_sync_w = sync_w[SYNC_BIT_TEST];
  assign nmi_sync_w  = sync_w[SYNC_BIT_NMI];
  assign rst_sync_w  = sync_w[SYNC_BIT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // Reset handling

  logic rst_seen_q;
  logic core_reset_q;
  logic restart_q;
  logic restart_d;

  assign restart_d = rst_seen_q & ~rst_sync_w;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_seen_q   <= 1'b0;
      core_reset_q <= 1'b0;
      restart_q    <= 1'b0;
    end else begin
      rst_seen_q   <= rst_sync_w;
      core_reset_q <= rst_sync_w;
      restart_q    <= restart_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle and read strobe

  bus_st_e bus_q;
  bus_st_e bus_d;
  logic    read_q;
  logic    read_d;
  logic    rd_n_q;
  logic    rd_n_d;
  logic    strobe_phase_w;

  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      BUS_IDLE:       bus_d = bus_start_i ? BUS_T1 : BUS_IDLE;
      BUS_T1:         bus_d = BUS_T2;
      BUS_T2:         bus_d = BUS_T3;
      BUS_T3:         bus_d = ready_i ? BUS_T4 : BUS_WAIT_STATE;
      BUS_WAIT_STATE: bus_d = ready_i ? BUS_T4 : BUS_WAIT_STATE;
      BUS_T4:         bus_d = BUS_IDLE;
      default:        bus_d = BUS_IDLE;
    endcase
    if (rst_sync_w) begin
      bus_d = BUS_IDLE;
    end
  end

  assign read_d = (bus_q == BUS_IDLE) ? (bus_start_i & bus_read_i) : read_q;

  // Strobe may only fall in T2 once the local bus is free, then holds low
  assign strobe_phase_w = (bus_d == BUS_T2 && bus_released_i)
                        || bus_d == BUS_T3 || bus_d == BUS_WAIT_STATE;
  assign rd_n_d = ~(read_d & strobe_phase_w & ~rst_sync_w);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_q  <= BUS_IDLE;
      read_q <= 1'b0;
      rd_n_q <= 1'b1;
    end else begin
      bus_q  <= bus_d;
      read_q <= read_d;
      rd_n_q <= rd_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt entry

  int_st_e                     int_q;
  int_st_e                     int_d;
  logic                        nmi_pend_w;
  logic                        nmi_take_w;
  logic                        irq_take_w;
  logic                        boundary_w;
  logic [VEC_TYPE_WIDTH-1:0]   type_q;
  logic [VEC_TYPE_WIDTH-1:0]   type_d;
  logic [VEC_ADDR_WIDTH-1:0]   addr_d;
  logic [VEC_ADDR_WIDTH-1:0]   addr_q;
  logic                        ack_q;
  logic                        fetch_q;

  nmi_edge_latch u_nmi (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .abort_i   (rst_sync_w),
    .level_i   (nmi_sync_w),
    .clear_i   (nmi_take_w),
    .pending_o (nmi_pend_w)
  );

  assign boundary_w = instr_last_i & (int_q == INT_IDLE) & ~rst_sync_w;
  // Enable flag gates only the maskable path; NMI wins when both are ready
  assign nmi_take_w = boundary_w & nmi_pend_w;
  assign irq_take_w = boundary_w & ~nmi_pend_w & irq_sync_w
                    & int_enable_i;

  always_comb begin
    int_d  = int_q;
    type_d = type_q;
    case (int_q)
      INT_IDLE: begin
        if (nmi_take_w) begin
          int_d  = INT_VEC;
          type_d = NMI_TYPE;
        end else if (irq_take_w) begin
          int_d  = INT_ACK;
        end
      end
      INT_ACK: begin
        if (ack_type_valid_i) begin
          int_d  = INT_VEC;
          type_d = ack_type_i;
        end
      end
      INT_VEC:  int_d = INT_IDLE;
      default:  int_d = INT_IDLE;
    endcase
    if (rst_sync_w) begin
      int_d = INT_IDLE;
    end
  end

  // Each table entry is four bytes
  assign addr_d = VEC_TABLE_BASE | {VEC_ADDR_PAD, type_d, VEC_ENTRY_LSBS};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_q   <= INT_IDLE;
      type_q  <= TYPE_RESET_VALUE;
      addr_q  <= VEC_TABLE_BASE;
      ack_q   <= 1'b0;
      fetch_q <= 1'b0;
    end else begin
      int_q   <= int_d;
      type_q  <= type_d;
      addr_q  <= addr_d;
      ack_q   <= (int_d == INT_ACK);
      fetch_q <= (int_d == INT_VEC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait-release test

  logic wait_idle_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_idle_q <= 1'b0;
    end else begin
      wait_idle_q <= wait_instr_i & test_sync_w & ~rst_sync_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_strobe_n_o  = rd_n_q;
  assign bus_state_o    = bus_q;
  assign irq_ack_o      = ack_q;
  assign vector_fetch_o = fetch_q;
  assign vector_addr_o  = addr_q;
  assign vector_type_o  = type_q;
  assign wait_idle_o    = wait_idle_q;
  assign core_reset_o   = core_reset_q;
  assign restart_o      = restart_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_strobe_in_phase: assert property (!rd_strobe_n_o |-> read_q &&
      (bus_q == BUS_T2 || bus_q == BUS_T3 || bus_q == BUS_WAIT_STATE))
    else $error("read strobe low outside T2/T3/wait");

  a_strobe_waits_bus: assert property (bus_d == BUS_T2 && !bus_released_i
      |=> rd_strobe_n_o)
    else $error("read strobe fell before bus release");

  a_not_ready_waits: assert property ((bus_q == BUS_T3 || bus_q == BUS_WAIT_STATE)
      && !ready_i && !rst_sync_w |=> bus_q == BUS_WAIT_STATE)
    else $error("no wait state while not ready");

  a_irq_taken: assert property (irq_take_w |=> irq_ack_o)
    else $error("active request not acknowledged");

  a_irq_masked: assert property (boundary_w && !int_enable_i && !nmi_pend_w
      |=> !irq_ack_o && !vector_fetch_o)
    else $error("masked request acknowledged");

  a_nmi_vector: assert property (nmi_take_w |=> vector_fetch_o &&
      vector_type_o == NMI_TYPE && vector_addr_o == {VEC_ADDR_PAD, NMI_TYPE, VEC_ENTRY_LSBS})
    else $error("nmi vector wrong");

  a_nmi_unmasked: assert property (boundary_w && nmi_pend_w && !int_enable_i
      |=> vector_fetch_o ##1 !vector_fetch_o)
    else $error("nmi blocked by enable flag");

  a_nmi_held: assert property (nmi_pend_w && !nmi_take_w && !rst_sync_w
      |=> nmi_pend_w)
    else $error("pending nmi lost");

  a_wait_idle: assert property (wait_instr_i && !rst_sync_w
      |=> wait_idle_o == $past(test_sync_w))
    else $error("wait idle does not follow test input");

  a_reset_abort: assert property (rst_sync_w |=> core_reset_o && rd_strobe_n_o
      && bus_q == BUS_IDLE && !irq_ack_o && !vector_fetch_o)
    else $error("activity continues under reset");

  // Restart is registered, so it shows one cycle after the synchronised fall
  a_restart_pulse: assert property ($fell(rst_sync_w) |=> restart_o ##1 !restart_o)
    else $error("no restart after reset release");

  c_wait_read: cover property (bus_q == BUS_WAIT_STATE && !rd_strobe_n_o ##1 bus_q == BUS_T4);
  c_irq_seq: cover property (irq_ack_o ##[1:20] vector_fetch_o);
  c_nmi_seq: cover property (nmi_take_w ##1 vector_fetch_o);
  c_wait_release: cover property (wait_idle_o ##1 !wait_idle_o);

endmodule : cpu_control_inputs

// File: verif/mem_io_model.sv
/*
  Far-side model: a memory or I/O device that answers with ready after a set
  number of wait states, and an interrupting device that returns its type.
  Assumes one processor clock and direct sight of the processor outputs.
*/
`timescale 1ns/1ps
module mem_io_model
  import cpu_ctrl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire bus_st_e    bus_state_i,
  input  wire logic       irq_ack_i,
  input  wire logic [3:0] waits_i,
  input  wire logic [7:0] type_i,
  output logic            ready_o,
  output logic            ack_type_valid_o,
  output logic [7:0]      ack_type_o
);
  logic [3:0] cnt_q;
  logic       sent_q;

  ////////////////////////////////////////////////////////////////////////////
  // Ready is made from a flop, so it is clock-synchronous at the pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q   <= 4'h0;
      ready_o <= 1'b1;
    end else if (bus_state_i == BUS_T2) begin
      cnt_q   <= waits_i;
      ready_o <= (waits_i == 4'h0);
    end else if (bus_state_i == BUS_T3 || bus_state_i == BUS_WAIT_STATE) begin
      cnt_q   <= (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
      ready_o <= (cnt_q <= 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Type is valid for one cycle only; otherwise the lines show its inverse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sent_q           <= 1'b0;
      ack_type_valid_o <= 1'b0;
    end else begin
      ack_type_valid_o <= irq_ack_i && !sent_q;
      sent_q           <= irq_ack_i;
    end
  end
  assign ack_type_o = ack_type_valid_o ? type_i : ~type_i;
endmodule : mem_io_model

// File: verif/cpu_control_inputs_tb.sv
/*
  Self-checking bench for the control-input logic: read cycles with waits,
  maskable and non-maskable entry, wait release and pin reset.
  Assumes the far side is the mem_io_model partner.
*/
`timescale 1ns/1ps
module cpu_control_inputs_tb
  import cpu_ctrl_pkg::*;
();
  logic       clk_i, rst_n_i, reset_i, ready_i, maskable_irq_in_i, test_i, nmi_i;
  logic       instr_last_i, int_enable_i, wait_instr_i, bus_start_i, bus_read_i;
  logic       bus_released_i, ack_type_valid_i, rd_strobe_n_o, irq_ack_o;
  logic       vector_fetch_o, wait_idle_o, core_reset_o, restart_o;
  logic [7:0] ack_type_i, vector_type_o, dev_type;
  logic [19:0] vector_addr_o;
  logic [3:0] waits;
  bus_st_e    bus_state_o;
  int         errors;
  int         checked;

  always #10 clk_i = ~clk_i;

  cpu_control_inputs i_cpu_control_inputs (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reset_i(reset_i), .ready_i(ready_i), .maskable_irq_in_i(maskable_irq_in_i),
    .test_i(test_i), .nmi_i(nmi_i), .instr_last_i(instr_last_i),
    .int_enable_i(int_enable_i), .wait_instr_i(wait_instr_i), .bus_start_i(bus_start_i),
    .bus_read_i(bus_read_i), .bus_released_i(bus_released_i),
    .ack_type_valid_i(ack_type_valid_i), .ack_type_i(ack_type_i),
    .rd_strobe_n_o(rd_strobe_n_o), .bus_state_o(bus_state_o), .irq_ack_o(irq_ack_o),
    .vector_fetch_o(vector_fetch_o), .vector_addr_o(vector_addr_o),
    .vector_type_o(vector_type_o), .wait_idle_o(wait_idle_o),
    .core_reset_o(core_reset_o), .restart_o(restart_o));

  mem_io_model i_mem_io_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_state_i(bus_state_o), .irq_ack_i(irq_ack_o), .waits_i(waits), .type_i(dev_type),
    .ready_o(ready_i), .ack_type_valid_o(ack_type_valid_i), .ack_type_o(ack_type_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic results();
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  task automatic rd_cycle(input logic [3:0] w, input logic rel);
    step(1);
    waits          <= w;
    bus_released_i <= rel;
    bus_start_i    <= 1'b1;
    step(1);
    bus_start_i <= 1'b0;
    #1 check(bus_state_o, BUS_T1);
    step(1);
    #1 check(rd_strobe_n_o, !rel);
    step(1);
    #1 check(rd_strobe_n_o, 1'b0);
    repeat (w) begin
      step(1);
      #1 check(bus_state_o, BUS_WAIT_STATE);
      check(rd_strobe_n_o, 1'b0);
    end
    step(1);
    #1 check(bus_state_o, BUS_T4);
    check(rd_strobe_n_o, 1'b1);
  endtask : rd_cycle

  // Write cycle with a wait state: the read strobe must never fall
  task automatic wr_cycle(input logic [3:0] w);
    step(1);
    waits          <= w;
    bus_released_i <= 1'b1;
    bus_read_i     <= 1'b0;
    bus_start_i    <= 1'b1;
    step(1);
    bus_start_i <= 1'b0;
    bus_read_i  <= 1'b1;
    #1 check(bus_state_o, BUS_T1);
    repeat (w + 2) begin
      step(1);
      #1 check(rd_strobe_n_o, 1'b1);
    end
    step(1);
    #1 check(bus_state_o, BUS_T4);
    check(rd_strobe_n_o, 1'b1);
  endtask : wr_cycle

  task automatic irq_case(input logic en, input logic [7:0] t);
    int n;
    step(3);
    dev_type          <= t;
    int_enable_i      <= en;
    maskable_irq_in_i <= 1'b1;
    instr_last_i      <= 1'b1;
    step(1);
    instr_last_i <= 1'b0;
    #1 check(irq_ack_o, 1'b0);
    step(1);
    instr_last_i <= 1'b1;
    step(1);
    instr_last_i <= 1'b0;
    #1 check(irq_ack_o, en);
    n = 0;
    while (vector_fetch_o !== 1'b1 && n < 6) begin
      step(1);
      #1 n++;
    end
    check(vector_fetch_o, en);
    check(irq_ack_o, 1'b0);
    if (en) check(vector_addr_o, {10'h000, t, 2'h0});
    if (en) check(vector_type_o, t);
    step(1);
    maskable_irq_in_i <= 1'b0;
  endtask : irq_case

  // One-cycle pulse, masked flag and a late boundary: the latch must hold it
  task automatic nmi_case();
    step(1);
    int_enable_i <= 1'b0;
    nmi_i        <= 1'b1;
    step(1);
    nmi_i <= 1'b0;
    repeat (6) begin
      step(1);
      #1 check(vector_fetch_o, 1'b0);
    end
    step(1);
    instr_last_i <= 1'b1;
    step(1);
    instr_last_i <= 1'b0;
    #1 check(vector_fetch_o, 1'b1);
    check(vector_type_o, NMI_TYPE);
    check(vector_addr_o, 20'h00008);
  endtask : nmi_case

  task automatic wait_case();
    step(1);
    wait_instr_i <= 1'b1;
    test_i       <= 1'b1;
    step(2);
    #1 check(wait_idle_o, 1'b0);
    step(1);
    #1 check(wait_idle_o, 1'b1);
    step(1);
    test_i <= 1'b0;
    step(3);
    #1 check(wait_idle_o, 1'b0);
  endtask : wait_case

  task automatic reset_case();
    int n;
    step(1);
    waits       <= 4'h2;
    bus_start_i <= 1'b1;
    step(1);
    bus_start_i <= 1'b0;
    reset_i     <= 1'b1;
    step(3);
    #1 check(bus_state_o, BUS_IDLE);
    check(rd_strobe_n_o, 1'b1);
    step(1);
    #1 check(core_reset_o, 1'b1);
    step(1);
    reset_i <= 1'b0;
    n = 0;
    while (restart_o !== 1'b1 && n < 8) begin
      step(1);
      #1 n++;
    end
    check(restart_o, 1'b1);
    check(core_reset_o, 1'b0);
  endtask : reset_case

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i             = 1'b0;
    rst_n_i           = 1'b0;
    reset_i           = 1'b0;
    maskable_irq_in_i = 1'b0;
    test_i            = 1'b0;
    nmi_i             = 1'b0;
    instr_last_i      = 1'b0;
    int_enable_i      = 1'b0;
    wait_instr_i      = 1'b0;
    bus_start_i       = 1'b0;
    bus_read_i        = 1'b1;
    bus_released_i    = 1'b1;
    waits             = 4'h0;
    dev_type          = 8'h00;
    errors            = 0;
    checked           = 0;
    step(20);
    rst_n_i <= 1'b1;
    rd_cycle(4'h0, 1'b1);
    rd_cycle(4'h2, 1'b0);
    rd_cycle(4'h1, 1'b1);
    wr_cycle(4'h1);
    irq_case(1'b1, 8'h5a);
    irq_case(1'b0, 8'h33);
    irq_case(1'b1, 8'hff);
    nmi_case();
    wait_case();
    reset_case();
    results();
  end

  // Whole run needs about 105 cycles; 2000 leaves ample room
  initial begin
    #(20 * 2000);
    errors++;
    results();
  end
endmodule : cpu_control_inputs_tb
